// File: design/cff_pkg.sv
// cff_pkg: constants for the cascaded fifo flag logic
// assumes one board clock and an active-low asynchronous reset
package cff_pkg;
  localparam int unsigned CFF_WORD_W   = 16;
  localparam int unsigned CFF_NCHIP    = 4;
  localparam int unsigned CFF_CHIP_AW  = 16;
  localparam int unsigned CFF_RING_AW  = 18;
  localparam int unsigned CFF_CNT_W    = 19;
  // capacity of one chip and of the ring, in 16-bit words
  localparam logic [18:0] CFF_CHIP_WORDS = 19'h1_0000;
  localparam logic [18:0] CFF_RING_WORDS = 19'h4_0000;
  // combined flag thresholds for the four-chip build
  localparam logic [18:0] CFF_AE_LO = 19'h0_FF80;
  localparam logic [18:0] CFF_AE_HI = 19'h1_FF00;
  localparam logic [18:0] CFF_AF_LO = 19'h1_FF00;
  localparam logic [18:0] CFF_AF_HI = 19'h2_FE80;
  // single-chip half-full point
  localparam logic [18:0] CFF_HALF_WORDS = 19'h0_8000;
  localparam logic [18:0] CFF_ONE        = 19'h0_0001;
  localparam logic [1:0]  CFF_CHIP_ONE   = 2'h1;
  localparam logic [1:0]  CFF_CHIP_ZERO  = 2'h0;
endpackage

// File: design/cff_chip_stat.sv
// cff_chip_stat: per-chip word count with empty and full status
// assumes writes are never made when full nor reads when empty
`timescale 1ns/1ps
module cff_chip_stat
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // strobes
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  // status
  output logic             empty_o,
  output logic             full_o
);
  typedef struct packed
  {
    logic [18:0] cnt;
  } cff_chip_type;

  cff_chip_type st_ff;
  cff_chip_type nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    if (wr_i && !rd_i)
      nxt_st.cnt = st_ff.cnt + cff_pkg::CFF_ONE;
    else if (rd_i && !wr_i)
      nxt_st.cnt = st_ff.cnt - cff_pkg::CFF_ONE;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign empty_o = (st_ff.cnt == '0);
  assign full_o  = (st_ff.cnt == cff_pkg::CFF_CHIP_WORDS);
endmodule // cff_chip_stat

// File: design/cff_flags.sv
// cff_flags: combined fifo flags for one chip or four chips in a ring
// assumes the writer stops at full and the reader stops at empty
`timescale 1ns/1ps
// Summary of operation
// - buffer is one 64K-word chip by default, or four chips cascaded
// - four chips fill and drain in ring order; flags use all chips
// - almost-empty low below 64K-128 words, high above 128K-256
// - almost-full low below 128K-256 words, high above 192K-384 with four chips; one chip: high above 64K-128
// - half-full is don't-care in four-chip build
module cff_flags
(
  // clock and reset
  input  wire logic        CLOCK_I,
  input  wire logic        RST_N_I,
  // build selection, held steady in operation
  input  wire logic        QUAD_BUILD_I,
  // writer side
  input  wire logic        WR_I,
  output logic             WR_READY_O,
  // reader side
  input  wire logic        RD_I,
  output logic             RD_VALID_O,
  // chip selects of the ring
  output logic [3:0]       WR_CHIP_O,
  output logic [3:0]       RD_CHIP_O,
  // combined flags
  output logic             EMPTY_O,
  output logic             ALMOST_EMPTY_O,
  output logic             HALF_FULL_O,
  output logic             ALMOST_FULL_O,
  output logic             FULL_O
);
  typedef struct packed
  {
    logic [18:0] level;
    logic [1:0]  wsel;
    logic [1:0]  rsel;
    logic [3:0]  wchip;
    logic [3:0]  rchip;
    logic [cff_pkg::CFF_RING_AW-1:0] wptr;
    logic [cff_pkg::CFF_RING_AW-1:0] rptr;
    logic        empty;
    logic        aempty;
    logic        half;
    logic        afull;
    logic        full;
    logic        ready;
    logic        valid;
  } cff_state_type;

  cff_state_type st_ff;
  cff_state_type nxt_st;
  logic [3:0]    chip_empty;
  logic [3:0]    chip_full;
  logic [3:0]    chip_wr;
  logic [3:0]    chip_rd;
  logic          wr_ok;
  logic          rd_ok;
  logic [18:0]   cap;

  // ring address: low bits index a word, top bits pick the chip
  localparam int unsigned sel_lo = cff_pkg::CFF_CHIP_AW;
  localparam int unsigned sel_hi = cff_pkg::CFF_RING_AW - 1;
  localparam logic [cff_pkg::CFF_RING_AW-1:0] ptr_one = 18'h0_0001;

  ////////////////////////////////////////////////////////////////////////
  // per-chip status, chip 0 alone in the single build
  always_comb
  begin
    cap   = QUAD_BUILD_I ? cff_pkg::CFF_RING_WORDS
                         : cff_pkg::CFF_CHIP_WORDS;
    wr_ok = WR_I && !st_ff.full;
    rd_ok = RD_I && !st_ff.empty;
    chip_wr = wr_ok ? (4'h1 << st_ff.wsel) : 4'h0;
    chip_rd = rd_ok ? (4'h1 << st_ff.rsel) : 4'h0;
  end

  genvar g;
  generate
    for (g = 0; g < cff_pkg::CFF_NCHIP; g++)
    begin : g_chip
      cff_chip_stat u_stat
      (
        .clk_i   (CLOCK_I),
        .rst_n_i (RST_N_I),
        .wr_i    (chip_wr[g]),
        .rd_i    (chip_rd[g]),
        .empty_o (chip_empty[g]),
        .full_o  (chip_full[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // ring pointers and combined level
  always_comb
  begin
    nxt_st = st_ff;
    if (wr_ok && !rd_ok)
      nxt_st.level = st_ff.level + cff_pkg::CFF_ONE;
    else if (rd_ok && !wr_ok)
      nxt_st.level = st_ff.level - cff_pkg::CFF_ONE;
    // word addresses wrap round the ring; a chip is left once its
    // last word is written or read, so no chip is ever over- or underrun
    if (wr_ok)
      nxt_st.wptr = st_ff.wptr + ptr_one;
    if (rd_ok)
      nxt_st.rptr = st_ff.rptr + ptr_one;
    if (QUAD_BUILD_I)
    begin
      nxt_st.wsel = nxt_st.wptr[sel_hi:sel_lo];
      nxt_st.rsel = nxt_st.rptr[sel_hi:sel_lo];
    end
    else
    begin
      nxt_st.wsel = cff_pkg::CFF_CHIP_ZERO;
      nxt_st.rsel = cff_pkg::CFF_CHIP_ZERO;
    end
    nxt_st.wchip = 4'h1 << nxt_st.wsel;
    nxt_st.rchip = 4'h1 << nxt_st.rsel;
    // exact thresholds, inside the allowed band
    nxt_st.empty  = (nxt_st.level == '0);
    nxt_st.full   = (nxt_st.level == cap);
    nxt_st.aempty = QUAD_BUILD_I ?
                    (nxt_st.level > cff_pkg::CFF_AE_LO) :
                    (nxt_st.level > cff_pkg::CFF_AE_LO);
    nxt_st.afull  = QUAD_BUILD_I ?
                    (nxt_st.level > cff_pkg::CFF_AF_LO) :
                    (nxt_st.level > cff_pkg::CFF_AE_LO);
    // no meaning with four chips; held low there
    nxt_st.half   = !QUAD_BUILD_I &&
                    (nxt_st.level >= cff_pkg::CFF_HALF_WORDS);
    // registered so the flow outputs come straight from flip-flops
    nxt_st.ready  = !nxt_st.full;
    nxt_st.valid  = !nxt_st.empty;
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      st_ff       <= '0;
      st_ff.empty <= 1'b1;
      st_ff.ready <= 1'b1;
      st_ff.wchip <= 4'h1;
      st_ff.rchip <= 4'h1;
    end
    else
      st_ff <= nxt_st;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops
  assign EMPTY_O        = st_ff.empty;
  assign FULL_O         = st_ff.full;
  assign ALMOST_EMPTY_O = st_ff.aempty;
  assign ALMOST_FULL_O  = st_ff.afull;
  assign HALF_FULL_O    = st_ff.half;
  assign WR_READY_O     = st_ff.ready;
  assign RD_VALID_O     = st_ff.valid;
  assign WR_CHIP_O      = st_ff.wchip;
  assign RD_CHIP_O      = st_ff.rchip;

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_empty_exact;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    EMPTY_O == (st_ff.level == '0);
  endproperty
  a_empty_exact: assert property (p_empty_exact)
    else $error("empty flag disagrees with level");

  property p_full_quad;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    QUAD_BUILD_I && FULL_O |-> st_ff.level == cff_pkg::CFF_RING_WORDS;
  endproperty
  a_full_quad: assert property (p_full_quad)
    else $error("full set before whole ring filled");

  property p_full_single;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    !QUAD_BUILD_I |-> FULL_O == (st_ff.level == cff_pkg::CFF_CHIP_WORDS);
  endproperty
  a_full_single: assert property (p_full_single)
    else $error("single chip full flag wrong");

  property p_ae_low;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    QUAD_BUILD_I && st_ff.level < cff_pkg::CFF_AE_LO |-> !ALMOST_EMPTY_O;
  endproperty
  a_ae_low: assert property (p_ae_low)
    else $error("almost empty high below lower bound");

  property p_ae_high;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    QUAD_BUILD_I && st_ff.level > cff_pkg::CFF_AE_HI |-> ALMOST_EMPTY_O;
  endproperty
  a_ae_high: assert property (p_ae_high)
    else $error("almost empty low above upper bound");

  property p_af_low;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    QUAD_BUILD_I && st_ff.level < cff_pkg::CFF_AF_LO |-> !ALMOST_FULL_O;
  endproperty
  a_af_low: assert property (p_af_low)
    else $error("almost full high below lower bound");

  property p_af_high;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    QUAD_BUILD_I && st_ff.level > cff_pkg::CFF_AF_HI |-> ALMOST_FULL_O;
  endproperty
  a_af_high: assert property (p_af_high)
    else $error("almost full low above upper bound");

  sequence s_write_taken;
    WR_I && WR_READY_O && !RD_I;
  endsequence
  property p_level_up;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    s_write_taken |=> st_ff.level == $past(st_ff.level) + cff_pkg::CFF_ONE;
  endproperty
  a_level_up: assert property (p_level_up)
    else $error("accepted write did not raise level");

  property p_chip_onehot;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    $onehot(WR_CHIP_O) && $onehot(RD_CHIP_O) &&
    (QUAD_BUILD_I || (WR_CHIP_O == 4'h1 && RD_CHIP_O == 4'h1));
  endproperty
  a_chip_onehot: assert property (p_chip_onehot)
    else $error("chip select not one-hot");

  // combined flags must agree with what the chips themselves report
  property p_chip_status;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    EMPTY_O == (&chip_empty) &&
    FULL_O == (QUAD_BUILD_I ? (&chip_full) : chip_full[0]);
  endproperty
  a_chip_status: assert property (p_chip_status)
    else $error("combined flags disagree with chip status");

  property p_chip_bounds;
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    (chip_wr & chip_full) == 4'h0 && (chip_rd & chip_empty) == 4'h0;
  endproperty
  a_chip_bounds: assert property (p_chip_bounds)
    else $error("chip written while full or read while empty");
endmodule // cff_flags

// File: verif/cff_strobe_model.sv
// cff_strobe_model: counter writer and host reader driving word strobes
// assumes strobes are judged against the flags after each rising edge
`timescale 1ns/1ps
module cff_strobe_model
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // demand from the bench
  input  wire logic want_wr_i,
  input  wire logic want_rd_i,
  // flow status of the fifo
  input  wire logic ready_i,
  input  wire logic valid_i,
  // word strobes
  output logic      wr_o,
  output logic      rd_o
);
  logic w;
  logic r;
  logic live;

  initial
  begin
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // demand lags one cycle, so the writer and reader look slow at times
  always @(posedge clk_i)
  begin
    w = want_wr_i;
    r = want_rd_i;
    live = rst_n_i;
    #1;
    wr_o = w & ready_i & live;
    rd_o = r & valid_i & live;
  end
endmodule // cff_strobe_model

// File: verif/tb_top.sv
// tb_top: random and corner traffic against the combined fifo flags
// assumes flags follow the stored level one edge after each strobe
`timescale 1ns/1ps
module tb_top;
  logic CLOCK_I, RST_N_I, QUAD_BUILD_I, WR_I, RD_I, want_wr, want_rd;
  logic WR_READY_O, RD_VALID_O, EMPTY_O, ALMOST_EMPTY_O, HALF_FULL_O;
  logic ALMOST_FULL_O, FULL_O;
  logic [3:0]  WR_CHIP_O, RD_CHIP_O;
  logic [18:0] lvl;
  logic [17:0] wtot, rtot;
  int          failures, comparisons, seed, rv;

  cff_flags dut (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I),
    .QUAD_BUILD_I(QUAD_BUILD_I), .WR_I(WR_I), .WR_READY_O(WR_READY_O),
    .RD_I(RD_I), .RD_VALID_O(RD_VALID_O), .WR_CHIP_O(WR_CHIP_O),
    .RD_CHIP_O(RD_CHIP_O), .EMPTY_O(EMPTY_O),
    .ALMOST_EMPTY_O(ALMOST_EMPTY_O), .HALF_FULL_O(HALF_FULL_O),
    .ALMOST_FULL_O(ALMOST_FULL_O), .FULL_O(FULL_O));
  cff_strobe_model partner (.clk_i(CLOCK_I), .rst_n_i(RST_N_I),
    .want_wr_i(want_wr), .want_rd_i(want_rd), .ready_i(WR_READY_O),
    .valid_i(RD_VALID_O), .wr_o(WR_I), .rd_o(RD_I));

  //////////////////////////////////////////////////////////////////////
  function automatic logic [6:0] exp_flags(input logic [18:0] l,
                                           input logic q);
    logic [18:0] cap;
    cap = q ? cff_pkg::CFF_RING_WORDS : cff_pkg::CFF_CHIP_WORDS;
    exp_flags = {l == 19'h0_0000, l > cff_pkg::CFF_AE_LO,
      !q && l >= cff_pkg::CFF_HALF_WORDS,
      l > (q ? cff_pkg::CFF_AF_LO : cff_pkg::CFF_AE_LO),
      l == cap, l != cap, l != 19'h0_0000};
  endfunction

  // ring order: each 64K-word chip in turn, chip 0 alone in single build
  function automatic logic [7:0] exp_chips(input logic [17:0] w,
                                           input logic [17:0] r,
                                           input logic q);
    exp_chips = q ? {4'h1 << w[17:16], 4'h1 << r[17:16]} : 8'h11;
  endfunction

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic step(input logic w, input logic r);
    @(posedge CLOCK_I);
    #1;
    want_wr = w;
    want_rd = r;
  endtask

  task automatic do_reset(input logic q);
    RST_N_I = 1'b0;
    QUAD_BUILD_I = q;
    repeat (6) @(posedge CLOCK_I);
    #1;
    RST_N_I = 1'b1;
  endtask

  // fill may overshoot a word or two; every level passed is still checked
  task automatic fill(input logic [18:0] n);
    while (lvl < n) step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    repeat (3) step(1'b0, 1'b0);
  endtask

  task automatic mix(input int n);
    repeat (n)
    begin
      rv = $random(seed);
      step(rv[0], rv[1]);
    end
  endtask

  task automatic finish_test;
    $display("counts: comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////
  initial
  begin
    CLOCK_I = 1'b0;
    forever #12.5 CLOCK_I = ~CLOCK_I;
  end

  always @(posedge CLOCK_I or negedge RST_N_I)
    if (!RST_N_I)
    begin
      lvl  <= 19'h0_0000;
      wtot <= 18'h0_0000;
      rtot <= 18'h0_0000;
    end
    else
    begin
      lvl  <= lvl + 19'(WR_I & WR_READY_O) - 19'(RD_I & RD_VALID_O);
      wtot <= wtot + 18'(WR_I & WR_READY_O);
      rtot <= rtot + 18'(RD_I & RD_VALID_O);
    end

  always @(posedge CLOCK_I)
  begin
    #2;
    if (RST_N_I === 1'b1)
    begin
      cmp({EMPTY_O, ALMOST_EMPTY_O, HALF_FULL_O, ALMOST_FULL_O, FULL_O,
        WR_READY_O, RD_VALID_O},
        exp_flags(lvl, QUAD_BUILD_I));
      cmp({WR_CHIP_O, RD_CHIP_O},
        exp_chips(wtot, rtot, QUAD_BUILD_I));
    end
  end

  // both fills dominate: about 65.5K plus 32.8K cycles, with margin
  initial
  begin
    repeat (104000) @(posedge CLOCK_I);
    failures++;
    finish_test();
  end

  initial
  begin
    seed = 32'h9f61_0456;
    failures = 0;
    comparisons = 0;
    want_wr = 1'b0;
    want_rd = 1'b0;
    do_reset(1'b1);
    cmp({WR_CHIP_O, RD_CHIP_O}, 8'h11);
    $display("test reset_state done");
    step(1'b1, 1'b0);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    mix(500);
    $display("test quad_random done");
    // just past one chip, so writing moves on to chip 1
    fill(cff_pkg::CFF_CHIP_WORDS + 19'h0_0004);
    cmp(WR_CHIP_O, 4'h2);
    cmp({ALMOST_EMPTY_O, WR_READY_O, lvl >= cff_pkg::CFF_AE_LO}, 3'h7);
    $display("test quad_almost_empty done");
    do_reset(1'b0);
    mix(500);
    $display("test single_random done");
    fill(cff_pkg::CFF_HALF_WORDS + 19'h0_0001);
    $display("test single_half_full done");
    finish_test();
  end
endmodule // tb_top
